// *** epod_consts.vh ***
`ifndef EPOD_CONSTS_VH
`define EPOD_CONSTS_VH
// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define EPOD_NUM_OUTPUTS 8
`define EPOD_DIR_RESET 1'b0
`define EPOD_OUT_RESET 1'b0
`define EPOD_IRQ_RESET 1'b0
`define EPOD_PIN_OE_RESET 1'b0
`define EPOD_DISABLED_RESET 1'b0
`endif

// *** epod_emu_line.v ***
`timescale 1ns/1ps
`include "epod_consts.vh"
module epod_emu_line (
	input wire clk,
	input wire rst,
	input wire emu_mode,
	input wire scan_dir_out,
	input wire scan_out_val,
	input wire pin_in,
	output reg pin_out,
	output reg pin_oe,
	output reg irq_in
);
	// ----------------------------------------
	// one emulator interrupt line
	// ----------------------------------------
	// direction and value come from scan; inactive outside emulation mode
	always @(posedge clk) begin
		if (rst) begin
			pin_out <= `EPOD_OUT_RESET;
			pin_oe <= `EPOD_DIR_RESET;
			irq_in <= `EPOD_IRQ_RESET;
		end else begin
			pin_out <= emu_mode & scan_dir_out & scan_out_val;
			pin_oe <= emu_mode & scan_dir_out;
			irq_in <= emu_mode & ~scan_dir_out & pin_in;
		end
	end
endmodule

// *** epod_top.v ***
// How it works
// - test reset low means normal mode; emulator scan controls are ignored
// - test reset high: line zero is a scan-directed emulator interrupt
// - test reset high: line one is a scan-directed emulator interrupt
// - test reset low: line one is an active-low output disable input, armed only while line zero is high
// - disable active forces every output driver to high impedance
`timescale 1ns/1ps
`include "epod_consts.vh"
module epod_top #(
	parameter NUM_OUTPUTS = `EPOD_NUM_OUTPUTS
) (
	input wire SYS_CLK,
	input wire RST,
	input wire TEST_RESET,
	input wire LINE_ZERO_SCAN_DIR,
	input wire LINE_ZERO_SCAN_VALUE,
	input wire LINE_ONE_SCAN_DIR,
	input wire LINE_ONE_SCAN_VALUE,
	input wire EMULATOR_LINE_ZERO_I,
	output wire EMULATOR_LINE_ZERO_O,
	output wire EMULATOR_LINE_ZERO_OE,
	input wire EMULATOR_LINE_ONE_DISABLE_I,
	output wire EMULATOR_LINE_ONE_DISABLE_O,
	output wire EMULATOR_LINE_ONE_DISABLE_OE,
	output wire LINE_ZERO_IRQ_IN,
	output wire LINE_ONE_IRQ_IN,
	input wire [NUM_OUTPUTS-1:0] CORE_OE,
	output wire [NUM_OUTPUTS-1:0] PIN_OE,
	output wire OUTPUTS_DISABLED
);

	// ----------------------------------------
	// mode encoding
	// ----------------------------------------
	// one-hot, so a corrupted code falls into the default branch
	localparam MODE_NORMAL = 3'b001;
	localparam MODE_EMU = 3'b010;
	localparam MODE_OFF = 3'b100;
	// two emulator lines, fixed by the pin count
	localparam NUM_LINES = 2;

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function is_off;
		input [2:0] mode;
		begin
			is_off = (mode == MODE_OFF);
		end
	endfunction

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	reg [2:0] mode_q;
	reg [2:0] mode_d;
	reg disabled_q;
	reg [NUM_OUTPUTS-1:0] pin_oe_d;
	reg [NUM_OUTPUTS-1:0] pin_oe_q;
	wire emu_mode;
	wire off_cond;
	wire [NUM_LINES-1:0] line_dir;
	wire [NUM_LINES-1:0] line_val;
	wire [NUM_LINES-1:0] line_in;
	wire [NUM_LINES-1:0] line_out;
	wire [NUM_LINES-1:0] line_oe;
	wire [NUM_LINES-1:0] line_irq;
	genvar g;

	// ----------------------------------------
	// mode select
	// ----------------------------------------
	// only a driven-high test reset enters emulation mode
	assign emu_mode = TEST_RESET;
	// all three terms at once; line one is only read, never driven, here
	// limitation: for one cycle after test reset falls the line may still
	// show our own emulation drive
	assign off_cond = ~TEST_RESET
		& EMULATOR_LINE_ZERO_I
		& ~EMULATOR_LINE_ONE_DISABLE_I;

	// ----------------------------------------
	// pin bundling
	// ----------------------------------------
	assign line_dir = {LINE_ONE_SCAN_DIR, LINE_ZERO_SCAN_DIR};
	assign line_val = {LINE_ONE_SCAN_VALUE, LINE_ZERO_SCAN_VALUE};
	assign line_in = {EMULATOR_LINE_ONE_DISABLE_I, EMULATOR_LINE_ZERO_I};

	// ----------------------------------------
	// emulator lines
	// ----------------------------------------
	generate
		for (g = 0; g < NUM_LINES; g = g + 1) begin : g_line
			epod_emu_line u_line (
				.clk(SYS_CLK),
				.rst(RST),
				.emu_mode(emu_mode),
				.scan_dir_out(line_dir[g]),
				.scan_out_val(line_val[g]),
				.pin_in(line_in[g]),
				.pin_out(line_out[g]),
				.pin_oe(line_oe[g]),
				.irq_in(line_irq[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// line outputs
	// ----------------------------------------
	assign EMULATOR_LINE_ZERO_O = line_out[0];
	assign EMULATOR_LINE_ZERO_OE = line_oe[0];
	assign LINE_ZERO_IRQ_IN = line_irq[0];
	assign EMULATOR_LINE_ONE_DISABLE_O = line_out[1];
	assign EMULATOR_LINE_ONE_DISABLE_OE = line_oe[1];
	assign LINE_ONE_IRQ_IN = line_irq[1];

	// ----------------------------------------
	// mode next state
	// ----------------------------------------
	// pins are levels, so every state re-judges them each cycle
	always @* begin
		mode_d = MODE_NORMAL;
		case (mode_q)
			MODE_NORMAL: begin
				if (TEST_RESET) begin
					mode_d = MODE_EMU;
				end else if (off_cond) begin
					mode_d = MODE_OFF;
				end else begin
					mode_d = MODE_NORMAL;
				end
			end
			MODE_EMU: begin
				if (TEST_RESET) begin
					mode_d = MODE_EMU;
				end else if (off_cond) begin
					mode_d = MODE_OFF;
				end else begin
					mode_d = MODE_NORMAL;
				end
			end
			MODE_OFF: begin
				if (TEST_RESET) begin
					mode_d = MODE_EMU;
				end else if (off_cond) begin
					mode_d = MODE_OFF;
				end else begin
					mode_d = MODE_NORMAL;
				end
			end
			default: begin
				mode_d = MODE_NORMAL;
			end
		endcase
	end

	// ----------------------------------------
	// mode register
	// ----------------------------------------
	// registered: one cycle of lag traded for glitch-free enables
	always @(posedge SYS_CLK) begin
		if (RST) begin
			mode_q <= MODE_NORMAL;
			disabled_q <= `EPOD_DISABLED_RESET;
		end else begin
			mode_q <= mode_d;
			disabled_q <= is_off(mode_d);
		end
	end

	// ----------------------------------------
	// output gating
	// ----------------------------------------
	always @* begin
		pin_oe_d = CORE_OE;
		if (is_off(mode_d)) begin
			pin_oe_d = {NUM_OUTPUTS{1'b0}};
		end
	end

	// ----------------------------------------
	// output enable registers
	// ----------------------------------------
	generate
		for (g = 0; g < NUM_OUTPUTS; g = g + 1) begin : g_pin
			always @(posedge SYS_CLK) begin
				if (RST) begin
					pin_oe_q[g] <= `EPOD_PIN_OE_RESET;
				end else begin
					pin_oe_q[g] <= pin_oe_d[g];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// status outputs
	// ----------------------------------------
	assign PIN_OE = pin_oe_q;
	assign OUTPUTS_DISABLED = disabled_q;
endmodule

// *** epod_sva.sv ***
`timescale 1ns/1ps
module epod_sva #(parameter NUM_OUTPUTS=8) (
	input wire SYS_CLK,
	input wire RST,
	input wire TEST_RESET,
	input wire LINE_ZERO_SCAN_DIR,
	input wire LINE_ZERO_SCAN_VALUE,
	input wire LINE_ONE_SCAN_DIR,
	input wire LINE_ONE_SCAN_VALUE,
	input wire EMULATOR_LINE_ZERO_I,
	input wire EMULATOR_LINE_ZERO_O,
	input wire EMULATOR_LINE_ZERO_OE,
	input wire EMULATOR_LINE_ONE_DISABLE_I,
	input wire EMULATOR_LINE_ONE_DISABLE_O,
	input wire EMULATOR_LINE_ONE_DISABLE_OE,
	input wire OUTPUTS_DISABLED,
	input wire [NUM_OUTPUTS-1:0] CORE_OE,
	input wire [NUM_OUTPUTS-1:0] PIN_OE
);
default clocking @(posedge SYS_CLK); endclocking
default disable iff (RST);
// all three pin terms at once, so one dropping frees the drivers
wire off=!TEST_RESET&&EMULATOR_LINE_ZERO_I&&!EMULATOR_LINE_ONE_DISABLE_I;
disable_flag_a:
assert property(!$past(RST)|->OUTPUTS_DISABLED==$past(off)) else $error("flag");
hiz_drivers_a:
assert property(OUTPUTS_DISABLED|->PIN_OE==0) else $error("hiz");
release_drivers_a:
assert property(!$past(RST)&&!$past(off)|->PIN_OE==$past(CORE_OE))
	else $error("b");
normal_mode_a:
assert property(!$past(RST)&&!$past(TEST_RESET)
	|->!EMULATOR_LINE_ZERO_OE&&!EMULATOR_LINE_ONE_DISABLE_OE) else $error("n");
line_zero_drive_a:
assert property(!$past(RST)&&$past(TEST_RESET)&&$past(LINE_ZERO_SCAN_DIR)
	|->EMULATOR_LINE_ZERO_OE
	&&EMULATOR_LINE_ZERO_O==$past(LINE_ZERO_SCAN_VALUE)) else $error("z");
line_one_drive_a:
assert property(!$past(RST)&&$past(TEST_RESET)&&$past(LINE_ONE_SCAN_DIR)
	|->EMULATOR_LINE_ONE_DISABLE_OE
	&&EMULATOR_LINE_ONE_DISABLE_O==$past(LINE_ONE_SCAN_VALUE)) else $error("o");
cover property(OUTPUTS_DISABLED);
cover property($fell(OUTPUTS_DISABLED));
cover property(EMULATOR_LINE_ZERO_OE);
endmodule
bind epod_top epod_sva #(.NUM_OUTPUTS(NUM_OUTPUTS)) u_sva(.*);

// *** epod_emu.sv ***
`timescale 1ns/1ps
module epod_emu(input wire [1:0] oe,input wire [1:0] o,input wire [1:0] v,
	output wire [1:0] ln);
// drives only where the device lets go; zero high arms the off state
assign ln=oe&o|~oe&v; // test use only, no sharing
endmodule

// *** tb_emulation_pin_output_disable.sv ***
`timescale 1ns/1ps
`define CK(a,b) begin cmp_count++; if((a)!==(b)) begin n_mismatch++; \
$display("wrong value %0t bad pin",$time); end end
module tb_emulation_pin_output_disable;
logic clk=0,rst=1,tr=0,dis;
logic [1:0] ev=0,e,o,ln,q;
logic [3:0] sc=0;
logic [7:0] ce=8'h5a,po;
int n_mismatch=0,cmp_count=0;
epod_top DUT(.SYS_CLK(clk),.RST(rst),.TEST_RESET(tr),
	.LINE_ZERO_SCAN_DIR(sc[1]),.LINE_ZERO_SCAN_VALUE(sc[0]),
	.LINE_ONE_SCAN_DIR(sc[3]),.LINE_ONE_SCAN_VALUE(sc[2]),
	.EMULATOR_LINE_ZERO_I(ln[0]),.EMULATOR_LINE_ZERO_O(o[0]),
	.EMULATOR_LINE_ZERO_OE(e[0]),.EMULATOR_LINE_ONE_DISABLE_I(ln[1]),
	.EMULATOR_LINE_ONE_DISABLE_O(o[1]),.EMULATOR_LINE_ONE_DISABLE_OE(e[1]),
	.LINE_ZERO_IRQ_IN(q[0]),.LINE_ONE_IRQ_IN(q[1]),.CORE_OE(ce),.PIN_OE(po),
	.OUTPUTS_DISABLED(dis));
epod_emu EMU(.oe(e),.o(o),.v(ev),.ln(ln));
// two edges: the line settles after the device lets go, then is sampled
task automatic go(input logic t,input logic [1:0] v,input logic [3:0] s);
	@(posedge clk);
	{tr,ev,sc}<={t,v,s};
	repeat(2) @(posedge clk);
	#1;
endtask
task tally_and_finish;
	$display("mismatches %0d checks %0d",n_mismatch,cmp_count);
	if(n_mismatch==0&&cmp_count>0) $display("Regression OK");
	else $display("Regression broken");
	$finish;
endtask
task t_off;
	go(0,2'b01,4'hf);
	`CK({dis,po,e},11'h400)
	`CK({o,q},4'h0)
	go(1,2'b01,4'h0);
	`CK({dis,po},{1'b0,ce})
	go(0,2'b01,4'hf);
	`CK(dis,1'b1)
	go(0,2'b11,4'hf);
	`CK({dis,po},{1'b0,ce})
	go(0,2'b00,4'hf);
	`CK({dis,po},{1'b0,ce})
	$display("t_off done");
endtask
task t_emu;
	go(1,2'b00,4'b1010);
	`CK({e,o},4'b1100)
	go(1,2'b10,4'h0);
	`CK({e,q},4'b0010)
	$display("t_emu done");
endtask
initial forever #5 clk=~clk;
initial begin
	#3000;
	n_mismatch++;
	tally_and_finish;
end
initial begin
	repeat(2) @(posedge clk);
	rst<=0;
	t_off;
	t_emu;
	tally_and_finish;
end
endmodule
